/* idc_pkg.sv */
// Constants, field layouts and carrier types of the identify command controller.
// What this block does
// RQ1: Host points the buffer at the data page itself, never a chained list.
// RQ2: Target controller id is taken from dword 10 bits 31:16, used only for 12h/13h.
// RQ3: Host writes zero into the controller id field when unused; zero is legal.
// RQ4: Host should keep the controller id zero for selectors 00h, 01h, 02h, 10h, 11h.
// RQ5: With namespace management present the controller id field is honoured.
// RQ6: Selector comes from dword 10 bits 7:0; bits 15:8 are reserved.
// RQ7: Bytes 1:0 carry the same vendor code as the configuration id register.
// RQ8: Bytes 3:2 carry the subsystem vendor code.
// RQ9: Bytes 23:4 carry the serial number string.
// RQ10: Bytes 63:24 carry the model number string.
// RQ11: Bytes 71:64 carry the active firmware revision string.
// RQ12: Byte 72 carries the suggested burst as a power-of-two exponent.
// RQ13: Bytes 75:73 carry the vendor organization unique identifier.
// RQ14: Capability byte 76: bits 7:3 zero, bit 2 set for a virtual function.
// RQ15: Capability bit 1 set when the subsystem may hold several controllers.
// RQ16: Capability bit 0 set when the subsystem may expose several ports.
// RQ17: Only the buffer pointer and dword 10 are used; other fields are reserved.
// RQ18: Selector 11h for an unallocated namespace returns an all-zero structure.
// RQ19: Multi-byte numeric fields go out least significant byte first.
package idc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the APB side)
  // ---------------------------------------------------------------
  localparam int unsigned IDC_ADDR_W = 12;
  localparam logic [11:0] IDC_OFS_CTRL = 12'h000;
  localparam logic [11:0] IDC_OFS_STATUS = 12'h004;
  localparam logic [11:0] IDC_OFS_CDW10 = 12'h008;
  localparam logic [11:0] IDC_OFS_PTR0 = 12'h00c;
  localparam logic [11:0] IDC_OFS_PTR3 = 12'h018;
  localparam logic [11:0] IDC_OFS_VENDOR = 12'h01c;
  localparam logic [11:0] IDC_OFS_MISC = 12'h020;
  localparam logic [11:0] IDC_OFS_CAPS = 12'h024;
  localparam logic [11:0] IDC_OFS_DECODE = 12'h028;
  localparam logic [11:0] IDC_OFS_STR = 12'h100;
  localparam int unsigned IDC_STR_WORDS = 17;
  localparam int unsigned IDC_PTR_WORDS = 4;

  // ---------------------------------------------------------------
  // Command dword 10 fields and selector codes
  // ---------------------------------------------------------------
  localparam int unsigned IDC_TARGET_CONTROLLER_ID_LSB = 16;
  localparam int unsigned IDC_SEL_LSB = 0;
  localparam logic [7:0] IDC_SEL_CTRL = 8'h01;
  localparam logic [7:0] IDC_SEL_NS = 8'h11;
  localparam logic [7:0] IDC_SEL_CLIST_NS = 8'h12;
  localparam logic [7:0] IDC_SEL_CLIST_ALL = 8'h13;

  // ---------------------------------------------------------------
  // Structure byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] IDC_B_VID = 12'h000;
  localparam logic [11:0] IDC_B_SUBSYSTEM_PCI_VENDOR_CODE = 12'h002;
  localparam logic [11:0] IDC_B_SN_FIRST = 12'h004;
  localparam logic [11:0] IDC_B_MN_FIRST = 12'h018;
  localparam logic [11:0] IDC_B_FR_FIRST = 12'h040;
  localparam logic [11:0] IDC_B_FR_LAST = 12'h047;
  localparam logic [11:0] IDC_B_RAB = 12'h048;
  localparam logic [11:0] IDC_B_OUI = 12'h049;
  localparam logic [11:0] IDC_B_MULTIPATH_SHARING_CAPS = 12'h04c;
  localparam int unsigned IDC_STRUCT_WORDS = 1024;

  // ---------------------------------------------------------------
  // Status, control and capability bit positions
  // ---------------------------------------------------------------
  localparam int unsigned IDC_CTRL_START = 0;
  localparam int unsigned IDC_ST_DONE = 0;
  localparam int unsigned IDC_ST_BADSEL = 1;
  localparam int unsigned IDC_CAP_MPORT = 0;
  localparam int unsigned IDC_CAP_MCTRL = 1;
  localparam int unsigned IDC_CAP_VF = 2;
  localparam int unsigned IDC_CAP_NSMGMT = 3;
  localparam int unsigned IDC_CAP_NSALLOC = 4;
  localparam logic [31:0] IDC_RST_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] vendor;
    logic [15:0] subsys_vendor;
    logic [7:0] burst_exp;
    logic [23:0] oui;
    logic is_vf;
    logic multi_ctrl;
    logic multi_port;
  } idc_cfg_t;

  typedef struct packed {
    logic valid;
    logic [63:0] addr;
    logic [31:0] data;
  } idc_wr_t;

endpackage

/* idc_byte_lane.sv */
// One byte lane of the controller data structure generator.
`timescale 1ns/1ps
`default_nettype none
module idc_byte_lane
  import idc_pkg::*;
#(
  parameter int unsigned LANE = 0
)
(
  // Position and sources
  input wire logic [11:0] byte_addr,
  input wire idc_cfg_t cfg,
  input wire logic [31:0] str_word,
  input wire logic zero_fill,
  // Result
  output logic [7:0] byte_val
);

  // ---------------------------------------------------------------
  // Byte selection
  // ---------------------------------------------------------------
  // Numeric fields put their low byte at the lowest offset; bytes beyond the covered
  // fields read as zero so the tail of the structure is well defined.
  always_comb
  begin
    byte_val = 8'h00;
    if (zero_fill)
    begin
      byte_val = 8'h00; // RQ18
    end
    else if (byte_addr == IDC_B_VID)
    begin
      byte_val = cfg.vendor[7:0]; // RQ7
    end
    else if (byte_addr == IDC_B_VID + 12'h001)
    begin
      byte_val = cfg.vendor[15:8]; // RQ19
    end
    else if (byte_addr == IDC_B_SUBSYSTEM_PCI_VENDOR_CODE)
    begin
      byte_val = cfg.subsys_vendor[7:0]; // RQ8
    end
    else if (byte_addr == IDC_B_SUBSYSTEM_PCI_VENDOR_CODE + 12'h001)
    begin
      byte_val = cfg.subsys_vendor[15:8]; // RQ19
    end
    else if (byte_addr >= IDC_B_SN_FIRST && byte_addr <= IDC_B_FR_LAST)
    begin
      byte_val = str_word[8*LANE +: 8]; // RQ9 RQ10 RQ11
    end
    else if (byte_addr == IDC_B_RAB)
    begin
      byte_val = cfg.burst_exp; // RQ12
    end
    else if (byte_addr == IDC_B_OUI)
    begin
      byte_val = cfg.oui[7:0]; // RQ13
    end
    else if (byte_addr == IDC_B_OUI + 12'h001)
    begin
      byte_val = cfg.oui[15:8];
    end
    else if (byte_addr == IDC_B_OUI + 12'h002)
    begin
      byte_val = cfg.oui[23:16];
    end
    else if (byte_addr == IDC_B_MULTIPATH_SHARING_CAPS)
    begin
      byte_val = {5'h00, cfg.is_vf, cfg.multi_ctrl, cfg.multi_port}; // RQ14 RQ15 RQ16
    end
  end

endmodule
`default_nettype wire

/* idc_identify_ctrl.sv */
// Identify command controller: APB registers, dword 10 decode and structure writer.
`timescale 1ns/1ps
`default_nettype none
module idc_identify_ctrl
  import idc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IDC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host memory write port
  output idc_wr_t host_wr,
  input wire logic host_wr_ready,
  // Engine state
  output logic busy
);

  typedef enum logic {IDC_IDLE, IDC_RUN} idc_state_t;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] cdw10_q, cdw10_d;
  logic [31:0] ptr_q [IDC_PTR_WORDS];
  logic [31:0] ptr_d [IDC_PTR_WORDS];
  logic [31:0] str_q [IDC_STR_WORDS];
  logic [31:0] str_d [IDC_STR_WORDS];
  idc_cfg_t cfg_q, cfg_d;
  logic ns_mgmt_q, ns_mgmt_d, ns_alloc_q, ns_alloc_d;
  logic done_q, done_d, badsel_q, badsel_d;
  logic [7:0] sel_q, sel_d;
  logic [15:0] target_controller_id_q, target_controller_id_d;
  idc_state_t state_q, state_d;
  logic [9:0] idx_q, idx_d;
  logic zero_q, zero_d;
  idc_wr_t wr_q, wr_d;
  logic wr_en, start, word_taken;
  logic [11:0] woff;
  logic [4:0] str_idx;
  logic [31:0] str_word, word_val;
  logic [9:0] next_idx;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign host_wr = wr_q;
  assign busy = (state_q == IDC_RUN);

  // One wait state; a write lands only on the edge where pready is seen high.
  assign wr_en = psel && penable && pwrite && pready_q;
  assign start = wr_en && (paddr == IDC_OFS_CTRL) && pwdata[IDC_CTRL_START] && (state_q == IDC_IDLE);
  assign woff = paddr - IDC_OFS_STR;
  assign word_taken = wr_q.valid && host_wr_ready;

  // ---------------------------------------------------------------
  // Register file next values
  // ---------------------------------------------------------------
  always_comb
  begin
    pready_d = psel && penable && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    cdw10_d = cdw10_q;
    ptr_d = ptr_q;
    str_d = str_q;
    cfg_d = cfg_q;
    ns_mgmt_d = ns_mgmt_q;
    ns_alloc_d = ns_alloc_q;
    if (psel && penable && !pready_q)
    begin
      prdata_d = IDC_RST_WORD;
      if (paddr == IDC_OFS_CTRL)
      begin
        prdata_d = {31'h0, state_q == IDC_RUN};
      end
      else if (paddr == IDC_OFS_STATUS)
      begin
        prdata_d = {30'h0, badsel_q, done_q};
      end
      else if (paddr == IDC_OFS_CDW10)
      begin
        prdata_d = cdw10_q;
      end
      else if (paddr >= IDC_OFS_PTR0 && paddr <= IDC_OFS_PTR3 && paddr[1:0] == 2'b00)
      begin
        prdata_d = ptr_q[2'((paddr - IDC_OFS_PTR0) >> 2)];
      end
      else if (paddr == IDC_OFS_VENDOR)
      begin
        prdata_d = {cfg_q.subsys_vendor, cfg_q.vendor};
      end
      else if (paddr == IDC_OFS_MISC)
      begin
        prdata_d = {cfg_q.oui, cfg_q.burst_exp};
      end
      else if (paddr == IDC_OFS_CAPS)
      begin
        prdata_d = {27'h0, ns_alloc_q, ns_mgmt_q, cfg_q.is_vf, cfg_q.multi_ctrl, cfg_q.multi_port};
      end
      else if (paddr == IDC_OFS_DECODE)
      begin
        prdata_d = {target_controller_id_q, 8'h00, sel_q};
      end
      else if (paddr >= IDC_OFS_STR && woff < 12'(IDC_STR_WORDS * 4) && paddr[1:0] == 2'b00)
      begin
        prdata_d = str_q[5'(woff >> 2)];
      end
      else
      begin
        pslverr_d = 1'b1;
      end
    end
    if (wr_en)
    begin
      if (paddr == IDC_OFS_CDW10)
      begin
        cdw10_d = pwdata;
      end
      else if (paddr >= IDC_OFS_PTR0 && paddr <= IDC_OFS_PTR3 && paddr[1:0] == 2'b00)
      begin
        ptr_d[2'((paddr - IDC_OFS_PTR0) >> 2)] = pwdata;
      end
      else if (paddr == IDC_OFS_VENDOR)
      begin
        cfg_d.vendor = pwdata[15:0];
        cfg_d.subsys_vendor = pwdata[31:16];
      end
      else if (paddr == IDC_OFS_MISC)
      begin
        cfg_d.burst_exp = pwdata[7:0];
        cfg_d.oui = pwdata[31:8];
      end
      else if (paddr == IDC_OFS_CAPS)
      begin
        cfg_d.multi_port = pwdata[IDC_CAP_MPORT];
        cfg_d.multi_ctrl = pwdata[IDC_CAP_MCTRL];
        cfg_d.is_vf = pwdata[IDC_CAP_VF];
        ns_mgmt_d = pwdata[IDC_CAP_NSMGMT];
        ns_alloc_d = pwdata[IDC_CAP_NSALLOC];
      end
      else if (paddr >= IDC_OFS_STR && woff < 12'(IDC_STR_WORDS * 4) && paddr[1:0] == 2'b00)
      begin
        str_d[5'(woff >> 2)] = pwdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command decode and structure engine next values
  // ---------------------------------------------------------------
  // Of the command fields only dword 10 and the pointer feed the engine, so any other command field has no path in.
  always_comb
  begin
    sel_d = sel_q;
    target_controller_id_d = target_controller_id_q;
    state_d = state_q;
    idx_d = idx_q;
    zero_d = zero_q;
    wr_d = wr_q;
    done_d = done_q;
    badsel_d = badsel_q;
    if (wr_en && paddr == IDC_OFS_STATUS)
    begin
      done_d = done_q && !pwdata[IDC_ST_DONE];
      badsel_d = badsel_q && !pwdata[IDC_ST_BADSEL];
    end
    if (start)
    begin
      sel_d = cdw10_q[IDC_SEL_LSB +: 8]; // RQ6 RQ17
      target_controller_id_d = 16'h0000;
      if (ns_mgmt_q && (cdw10_q[IDC_SEL_LSB +: 8] == IDC_SEL_CLIST_NS ||
                        cdw10_q[IDC_SEL_LSB +: 8] == IDC_SEL_CLIST_ALL))
      begin
        target_controller_id_d = cdw10_q[IDC_TARGET_CONTROLLER_ID_LSB +: 16]; // RQ2 RQ5
      end
      if (cdw10_q[IDC_SEL_LSB +: 8] == IDC_SEL_CTRL ||
          (cdw10_q[IDC_SEL_LSB +: 8] == IDC_SEL_NS && !ns_alloc_q))
      begin
        state_d = IDC_RUN;
        idx_d = 10'h000;
        zero_d = (cdw10_q[IDC_SEL_LSB +: 8] == IDC_SEL_NS); // RQ18
        wr_d.valid = 1'b1;
      end
      else
      begin
        badsel_d = 1'b1; // Lists, allocated namespaces and any selector other than 01h or 11h are served elsewhere.
        done_d = 1'b1;
      end
    end
    else if (state_q == IDC_RUN && word_taken)
    begin
      if (idx_q == 10'(IDC_STRUCT_WORDS - 1))
      begin
        state_d = IDC_IDLE;
        wr_d.valid = 1'b0;
        done_d = 1'b1; // Set beats a same-cycle clear.
      end
      else
      begin
        idx_d = next_idx;
      end
    end
    if (start || (state_q == IDC_RUN && word_taken))
    begin
      // Pointer entries 1 and 0 form the page address directly; list chaining is never followed.
      wr_d.addr = {ptr_q[1], ptr_q[0]} + {52'h0, next_idx, 2'b00}; // RQ1
      wr_d.data = word_val;
    end
  end

  // Index of the word presented next. It lives outside the engine process because the byte
  // lanes read it and feed that process, which would otherwise look like a loop to lint.
  assign next_idx = start ? 10'h000 :
    (state_q == IDC_RUN && word_taken && idx_q != 10'(IDC_STRUCT_WORDS - 1)) ? idx_q + 10'h001 : idx_q;

  // String words cover structure words 1 to 17.
  assign str_idx = 5'(next_idx - 10'h001);
  assign str_word = (next_idx >= 10'h001 && next_idx <= 10'(IDC_STR_WORDS)) ? str_q[str_idx] : 32'h0;

  // ---------------------------------------------------------------
  // Byte lanes of the next word
  // ---------------------------------------------------------------
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      idc_byte_lane #(.LANE(lane)) u_lane (
        .byte_addr({next_idx, 2'(lane)}),
        .cfg(cfg_q),
        .str_word(str_word),
        .zero_fill(start ? (cdw10_q[IDC_SEL_LSB +: 8] == IDC_SEL_NS) : zero_q),
        .byte_val(word_val[8*lane +: 8])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= IDC_RST_WORD;
      cdw10_q <= IDC_RST_WORD;
      for (int i = 0; i < IDC_PTR_WORDS; i++) ptr_q[i] <= IDC_RST_WORD;
      for (int i = 0; i < IDC_STR_WORDS; i++) str_q[i] <= IDC_RST_WORD;
      cfg_q <= '0;
      ns_mgmt_q <= 1'b0;
      ns_alloc_q <= 1'b0;
      done_q <= 1'b0;
      badsel_q <= 1'b0;
      sel_q <= 8'h00;
      target_controller_id_q <= 16'h0000;
      state_q <= IDC_IDLE;
      idx_q <= 10'h000;
      zero_q <= 1'b0;
      wr_q <= '0;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      cdw10_q <= cdw10_d;
      ptr_q <= ptr_d;
      str_q <= str_d;
      cfg_q <= cfg_d;
      ns_mgmt_q <= ns_mgmt_d;
      ns_alloc_q <= ns_alloc_d;
      done_q <= done_d;
      badsel_q <= badsel_d;
      sel_q <= sel_d;
      target_controller_id_q <= target_controller_id_d;
      state_q <= state_d;
      idx_q <= idx_d;
      zero_q <= zero_d;
      wr_q <= wr_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_target_controller_id_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    target_controller_id_q != 16'h0000 |-> (sel_q == IDC_SEL_CLIST_NS || sel_q == IDC_SEL_CLIST_ALL))
    else $error("controller id kept for a selector that does not use it");
  a_target_controller_id_honour: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    start && ns_mgmt_q && cdw10_q[IDC_SEL_LSB +: 8] == IDC_SEL_CLIST_NS |=> target_controller_id_q == $past(cdw10_q[IDC_TARGET_CONTROLLER_ID_LSB +: 16]))
    else $error("controller id not honoured");
  a_sel_taken: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    start |=> sel_q == $past(cdw10_q[IDC_SEL_LSB +: 8]))
    else $error("selector not taken from dword 10 low byte");
  a_vendor_word: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    wr_q.valid && idx_q == 10'h000 && !zero_q |-> wr_q.data == {cfg_q.subsys_vendor, cfg_q.vendor})
    else $error("vendor codes misplaced");
  a_subsystem_pci_vendor_code_high: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    wr_q.valid && idx_q == 10'h000 && !zero_q |-> wr_q.data[31:16] == cfg_q.subsys_vendor)
    else $error("subsystem vendor code misplaced");
  a_serial_words: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    wr_q.valid && !zero_q && idx_q >= 10'd1 && idx_q <= 10'd5 |-> wr_q.data == str_q[5'(idx_q - 10'd1)])
    else $error("serial string misplaced");
  a_model_words: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    wr_q.valid && !zero_q && idx_q >= 10'd6 && idx_q <= 10'd15 |-> wr_q.data == str_q[5'(idx_q - 10'd1)])
    else $error("model string misplaced");
  a_fw_words: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    wr_q.valid && !zero_q && idx_q >= 10'd16 && idx_q <= 10'd17 |-> wr_q.data == str_q[5'(idx_q - 10'd1)])
    else $error("firmware string misplaced");
  a_burst_oui: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    wr_q.valid && !zero_q && idx_q == 10'd18 |-> wr_q.data == {cfg_q.oui, cfg_q.burst_exp})
    else $error("burst or identifier bytes misplaced");
  a_oui_order: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    wr_q.valid && !zero_q && idx_q == 10'd18 |-> wr_q.data[15:8] == cfg_q.oui[7:0])
    else $error("identifier not low byte first");
  a_caps_byte: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    wr_q.valid && !zero_q && idx_q == 10'd19 |-> wr_q.data[7:2] == {5'h00, cfg_q.is_vf})
    else $error("capability high bits wrong");
  a_caps_ctrl: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    wr_q.valid && !zero_q && idx_q == 10'd19 |-> wr_q.data[1] == cfg_q.multi_ctrl)
    else $error("multi controller bit wrong");
  a_caps_port: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
    wr_q.valid && !zero_q && idx_q == 10'd19 |-> wr_q.data[0] == cfg_q.multi_port && wr_q.data[31:8] == 24'h0)
    else $error("multi port bit wrong");
  a_zero_struct: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
    wr_q.valid && zero_q |-> wr_q.data == 32'h0)
    else $error("unallocated namespace data not zero");
  a_word_addr: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
    wr_q.valid |-> wr_q.addr == {ptr_q[1], ptr_q[0]} + {52'h0, idx_q, 2'b00})
    else $error("word address off");
  a_hold_stall: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    wr_q.valid && !host_wr_ready |=> wr_q.valid && $stable(wr_q.data) && $stable(wr_q.addr))
    else $error("write dropped under stall");
  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");

endmodule
`default_nettype wire

/* idc_host_mem.sv */
// Host memory model that takes structure words from the controller's write port.
`timescale 1ns/1ps
`default_nettype none
module idc_host_mem
  import idc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port from the controller
  input wire idc_wr_t host_wr,
  input wire logic slow,
  output logic host_wr_ready
);
  logic [7:0] lfsr_q;
  logic [31:0] mem [1024];

  // A slow host stalls on a pseudo-random pattern, so the writer must hold each word.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lfsr_q <= 8'h5a;
      host_wr_ready <= 1'b0;
    end
    else
    begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      host_wr_ready <= !slow || lfsr_q[0];
    end
  end

  // The buffer is one data page reached directly, so the word index is the page offset.
  always_ff @(posedge pclk)
  begin
    if (host_wr.valid && host_wr_ready)
      mem[host_wr.addr[11:2]] <= host_wr.data;
  end
endmodule
`default_nettype wire

/* identify_cmd_controller_data_tb.sv */
// Self-checking bench for the identify command controller.
`timescale 1ns/1ps
`default_nettype none
module identify_cmd_controller_data_tb
  import idc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, host_wr_ready, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rng, ven, misc, cdw;
  logic [31:0] str [17];
  logic [63:0] ptr;
  logic [2:0] cap3;
  idc_wr_t host_wr;
  int fails, n_checks;
  logic [32:0] q_rd [$];
  logic [95:0] q_wr [$];
  logic [7:0] sels [7] = '{8'h01, 8'h12, 8'h13, 8'h13, 8'h11, 8'h11, 8'h00};
  logic [1:0] nss [7] = '{2'b01, 2'b01, 2'b00, 2'b01, 2'b00, 2'b10, 2'b01};

  idc_identify_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_wr(host_wr),
    .host_wr_ready(host_wr_ready), .busy(busy));
  idc_host_mem u_host (.pclk(pclk), .presetn(presetn), .host_wr(host_wr), .slow(slow),
    .host_wr_ready(host_wr_ready));

  // Free-running bus clock.
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; a read notes its expected slave-error bit and data first.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    if (!w)
      q_rd.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      fails++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Expected structure byte; numeric fields lowest byte first, unlisted bytes zero.
  function automatic logic [7:0] sb(int n);
    if (n < 4)
      return ven[8*n +: 8];
    if (n < 72)
      return str[(n-4)/4][8*((n-4)%4) +: 8];
    if (n < 76)
      return misc[8*(n-72) +: 8];
    return (n == 76) ? {5'h00, cap3} : 8'h00;
  endfunction

  task automatic exp_struct(input logic zero);
    for (int i = 0; i < IDC_STRUCT_WORDS; i++)
      q_wr.push_back({ptr + 64'(4*i), zero ? 32'h0 : {sb(4*i+3), sb(4*i+2), sb(4*i+1), sb(4*i)}});
  endtask

  // Issue one command and check what it decoded and how it ended.
  task automatic cmd(input logic [7:0] sel, input logic [1:0] ns);
    logic go;
    logic [15:0] cid;
    int n;
    go = (sel == IDC_SEL_CTRL) || (sel == IDC_SEL_NS && !ns[1]);
    cid = (sel == IDC_SEL_CLIST_NS || sel == IDC_SEL_CLIST_ALL) ? 16'(xs() >> 16) : 16'h0000;
    cdw = xs();
    cdw[7:0] = sel;
    cdw[31:16] = cid;
    apb(1'b1, IDC_OFS_CAPS, {27'h0, ns, cap3}, 33'h0);
    apb(1'b1, IDC_OFS_CDW10, cdw, 33'h0);
    if (go)
      exp_struct(sel == IDC_SEL_NS);
    apb(1'b1, IDC_OFS_CTRL, 32'h1, 33'h0);
    // A second start while streaming must not queue another structure.
    if (go)
      apb(1'b1, IDC_OFS_CTRL, 32'h1, 33'h0);
    // Busy reads back high only while a structure is still streaming.
    apb(1'b0, IDC_OFS_CTRL, 32'h0, {32'h0, go});
    n = 0;
    while (busy !== 1'b0 && n < 8000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 8000)
      fails++;
    apb(1'b0, IDC_OFS_DECODE, 32'h0, {1'b0, (sel[7:1] == 7'h09 && ns[0]) ? cid : 16'h0, 8'h00, sel});
    apb(1'b0, IDC_OFS_STATUS, 32'h0, {31'h0, !go, 1'b1});
    apb(1'b1, IDC_OFS_STATUS, 32'h3, 33'h0);
    apb(1'b0, IDC_OFS_STATUS, 32'h0, 33'h0);
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watcher: every completed read and every taken memory word settles the oldest note.
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk(96'({pslverr, prdata}), 96'(q_rd.pop_front()));
    if (host_wr.valid === 1'b1 && host_wr_ready)
      chk({host_wr.addr, host_wr.data}, q_wr.pop_front());
  end

  // Whole run needs well under ten thousand cycles; this cuts a hang short.
  initial
  begin
    repeat (30000) @(posedge pclk);
    fails++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rng = 32'h0000002a;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slow = 1'b1;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDC_OFS_STATUS, 32'h0, 33'h0);
    apb(1'b0, 12'h3fc, 32'h0, {1'b1, 32'h0});
    ven = xs();
    misc = xs();
    cap3 = rng[10:8];
    ptr = {xs(), 32'h0};
    ptr[31:0] = xs() & 32'hfffff000;
    apb(1'b1, IDC_OFS_VENDOR, ven, 33'h0);
    apb(1'b1, IDC_OFS_MISC, misc, 33'h0);
    for (int k = 0; k < IDC_PTR_WORDS; k++)
      apb(1'b1, IDC_OFS_PTR0 + 12'(4*k), k == 0 ? ptr[31:0] : k == 1 ? ptr[63:32] : xs(), 33'h0);
    for (int k = 0; k < IDC_STR_WORDS; k++)
    begin
      str[k] = (xs() & 32'h3f3f3f3f) | 32'h20202020;
      apb(1'b1, IDC_OFS_STR + 12'(4*k), str[k], 33'h0);
    end
    for (int i = 0; i < 7; i++)
    begin
      slow <= (i == 0);
      cmd(sels[i], nss[i]);
    end
    chk(96'(q_wr.size()), 96'h0);
    chk(96'(q_rd.size()), 96'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
